// ---- logic/read_latency_monitor_cfg.svh ----
// Offsets, field positions, reset values and codes of the read latency monitor
`ifndef READ_LATENCY_MONITOR_CFG_SVH
`define READ_LATENCY_MONITOR_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_MAP_7_4        12'h510
`define ADDR_MAP_3_0        12'h514
`define ADDR_MAP_15_12      12'h518
`define ADDR_MAP_11_8       12'h51C
`define ADDR_ID_ENABLE      12'h524
`define ADDR_ID_ENABLE_OLD  12'h250
`define ADDR_CHECK_CTL      12'h530
`define ADDR_LATE_COUNT     12'h534
`define ADDR_SAMPLE_COUNT   12'h538
`define ADDR_LATENCY_SUM    12'h53C
`define ADDR_CHECK_CTL_OLD  12'h260

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define BIT_CHECK_ENABLE    31
`define BIT_COUNTER_TEST    30
`define BIT_TIMER_TEST      29
`define BIT_LAST_BEAT       28
`define LIMIT_MSB           27
`define LIMIT_LSB           16
`define CYCLES_MSB          11
`define CYCLES_LSB          0

// ----------------------------------------------------------------
// Widths, terminal values and reset values
// ----------------------------------------------------------------
`define TIMER_W             12
`define COUNT_W             20
`define SUM_W               32
`define TIMER_ZERO          12'h000
`define TIMER_TEST_START    12'hFF0
`define TIMER_MAX           12'hFFF
`define COUNT_MAX           20'hFFFFF
`define SUM_MAX             32'h0FFFFFFF
`define CTL_RESET           32'h00000000
`define NUM_IDS             16
`define NUM_REQUESTERS      3

// ----------------------------------------------------------------
// Requester block codes
// ----------------------------------------------------------------
`define CODE_JOB_RINGS      8'h01
`define CODE_BURST_BUFFER   8'h04
`define CODE_DESC_CTRL_0    8'h08

`endif

// ---- logic/read_latency_monitor_pkg.sv ----
// Types shared by the read latency monitor
package read_latency_monitor_pkg;

    typedef enum logic [1:0] {
        ST_WAIT_ADDR = 2'b01,
        ST_MEASURE   = 2'b10
    } monitor_state_t;

    typedef logic [3:0] axi_id_t;

endpackage : read_latency_monitor_pkg

// ---- logic/read_latency_monitor.sv ----
// AXI read latency monitor with hardwired ID map and requester ID allocation
//
// The plain strobed port is this design's own decision.
`include "read_latency_monitor_cfg.svh"

module read_latency_monitor
    import read_latency_monitor_pkg::*;
(
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire logic [11:0]                reg_addr,
    input  wire logic [31:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [31:0]                reg_rdata,
    input  wire logic [127:0]               id_map_strap,
    input  wire logic [15:0]                id_enable_strap,
    input  wire logic                       ar_valid,
    input  wire logic                       ar_ready,
    input  wire logic [3:0]                 ar_id,
    input  wire logic                       r_valid,
    input  wire logic                       r_ready,
    input  wire logic [3:0]                 r_id,
    input  wire logic                       r_last,
    output logic      [3:0]                 job_ring_axi_id,
    output logic      [3:0]                 burst_buffer_axi_id,
    output logic      [3:0]                 descriptor_controller_zero_axi_id,
    output logic      [2:0]                 requester_id_valid,
    output logic                            check_suspended
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Map word for four IDs, disabled IDs masked to zero
    function automatic logic [31:0] map_word(input logic [127:0] map, input logic [15:0] en,
                                             input int base);
        logic [31:0] w;
        w = 32'h00000000;
        for (int k = 0; k < 4; k++) begin
            if (en[base + k]) begin
                w[k*8 +: 8] = map[(base + k)*8 +: 8];
            end
        end
        return w;
    endfunction : map_word

    // Position of the n-th lowest enabled ID, bit 4 marks found
    function automatic logic [4:0] nth_enabled(input logic [15:0] en, input int n);
        logic [4:0] res;
        int         seen;
        res  = 5'h00;
        seen = 0;
        for (int k = 0; k < `NUM_IDS; k++) begin
            if (en[k] && !res[4]) begin
                if (seen == n) begin
                    res = {1'b1, 4'(k)};
                end
                seen = seen + 1;
            end
        end
        return res;
    endfunction : nth_enabled

    // ----------------------------------------------------------------
    // Strap synchronisers
    // ----------------------------------------------------------------
    logic [127:0]           map_meta;
    logic [127:0]           id_map;
    logic [15:0]            en_meta;
    logic [15:0]            id_enable;

    // Straps are static, but still cross from outside the clock
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            map_meta  <= '0;
            id_map    <= '0;
            en_meta   <= 16'h0000;
            id_enable <= 16'h0000;
        end else begin
            map_meta  <= id_map_strap;
            id_map    <= map_meta;
            en_meta   <= id_enable_strap;
            id_enable <= en_meta;
        end
    end

    // ----------------------------------------------------------------
    // Requester ID allocation
    // ----------------------------------------------------------------
    logic [4:0]             alloc_job;
    logic [4:0]             alloc_burst;
    logic [4:0]             alloc_desc;

    always_comb begin
        alloc_job   = nth_enabled(id_enable, 0);
        alloc_burst = nth_enabled(id_enable, 1);
        alloc_desc  = nth_enabled(id_enable, 2);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            job_ring_axi_id                   <= 4'h0;
            burst_buffer_axi_id               <= 4'h0;
            descriptor_controller_zero_axi_id <= 4'h0;
            requester_id_valid                <= 3'h0;
        end else begin
            job_ring_axi_id                   <= alloc_job[3:0];
            burst_buffer_axi_id               <= alloc_burst[3:0];
            descriptor_controller_zero_axi_id <= alloc_desc[3:0];
            requester_id_valid <= {alloc_desc[4], alloc_burst[4], alloc_job[4]};
        end
    end

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    logic                   read_check_enable;
    logic                   counter_test_hold;
    logic                   timer_test_preload;
    logic                   last_beat_select;
    logic [11:0]            late_limit;
    logic                   wr_ctl;
    logic                   rd_ctl;
    logic                   rd_lat;
    logic                   enable_rise;

    always_comb begin
        // Both copies land on the same flops
        wr_ctl = reg_wr && (reg_addr == `ADDR_CHECK_CTL || reg_addr == `ADDR_CHECK_CTL_OLD);
        rd_ctl = reg_rd && (reg_addr == `ADDR_CHECK_CTL || reg_addr == `ADDR_CHECK_CTL_OLD);
        rd_lat = reg_rd && (reg_addr == `ADDR_LATENCY_SUM);
        enable_rise = wr_ctl && reg_wdata[`BIT_CHECK_ENABLE] && !read_check_enable;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            read_check_enable  <= 1'b0;
            counter_test_hold  <= 1'b0;
            timer_test_preload <= 1'b0;
            last_beat_select   <= 1'b0;
            late_limit         <= 12'h000;
        end else if (wr_ctl) begin
            read_check_enable  <= reg_wdata[`BIT_CHECK_ENABLE];
            counter_test_hold  <= reg_wdata[`BIT_COUNTER_TEST];
            timer_test_preload <= reg_wdata[`BIT_TIMER_TEST];
            last_beat_select   <= reg_wdata[`BIT_LAST_BEAT];
            if (!read_check_enable) begin
                late_limit <= reg_wdata[`LIMIT_MSB:`LIMIT_LSB];
            end
        end
    end

    // ----------------------------------------------------------------
    // Measurement sequencer
    // ----------------------------------------------------------------
    monitor_state_t         state;
    monitor_state_t         next_state;
    axi_id_t                tracked_id;
    logic [11:0]            timer;
    logic                   active;
    logic                   addr_taken;
    logic                   beat_hit;
    logic                   done;

    always_comb begin
        active     = read_check_enable && !check_suspended;
        addr_taken = active && state == ST_WAIT_ADDR && ar_valid && ar_ready;
        beat_hit   = r_valid && r_ready && r_id == tracked_id
                     && (!last_beat_select || r_last);
        done       = active && state == ST_MEASURE && beat_hit;
        next_state = state;
        case (state)
            ST_WAIT_ADDR: begin
                if (addr_taken) begin
                    next_state = ST_MEASURE;
                end
            end
            ST_MEASURE: begin
                // Other reads pass unobserved until this one ends
                if (done || !active || rd_lat) begin
                    next_state = ST_WAIT_ADDR;
                end
            end
            default: begin
                next_state = ST_WAIT_ADDR;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_WAIT_ADDR;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tracked_id <= 4'h0;
        end else if (addr_taken) begin
            tracked_id <= ar_id;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timer <= `TIMER_ZERO;
        end else if (addr_taken) begin
            timer <= timer_test_preload ? `TIMER_TEST_START : `TIMER_ZERO;
        end else if (state == ST_MEASURE && timer != `TIMER_MAX) begin
            timer <= timer + 12'h001;
        end
    end

    // ----------------------------------------------------------------
    // Measured latency
    // ----------------------------------------------------------------
    logic [11:0]            latency;

    always_comb begin
        // The data beat's own edge counts, so one is added; held at the top
        if (timer == `TIMER_MAX) begin
            latency = `TIMER_MAX;
        end else begin
            latency = timer + 12'h001;
        end
    end

    // ----------------------------------------------------------------
    // Counters
    // ----------------------------------------------------------------
    logic [11:0]            latest_read_cycles;
    logic [19:0]            late_counter;
    logic [19:0]            sample_counter;
    logic [31:0]            latency_sum;
    logic [19:0]            next_late_counter;
    logic [19:0]            next_sample_counter;
    logic [31:0]            next_latency_sum;
    logic                   clear_now;
    logic                   wr_open;

    always_comb begin
        // On enable the test bit being written decides, not the old one
        clear_now = (enable_rise && !reg_wdata[`BIT_COUNTER_TEST])
                    || (read_check_enable && rd_lat && !counter_test_hold);
        next_late_counter   = clear_now ? 20'h00000 : late_counter;
        next_sample_counter = clear_now ? 20'h00000 : sample_counter;
        next_latency_sum    = clear_now ? 32'h00000000 : latency_sum;
        // A completion in the clearing cycle is kept, not lost
        if (done) begin
            next_sample_counter = next_sample_counter + 20'h00001;
            next_latency_sum    = next_latency_sum + {20'h00000, latency};
            if (latency >= late_limit) begin
                next_late_counter = next_late_counter + 20'h00001;
            end
        end
        wr_open = reg_wr && !read_check_enable;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            latest_read_cycles <= 12'h000;
        end else if (done) begin
            latest_read_cycles <= latency;
        end else if (wr_open && wr_ctl) begin
            latest_read_cycles <= reg_wdata[`CYCLES_MSB:`CYCLES_LSB];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            late_counter <= 20'h00000;
        end else if (wr_open && reg_addr == `ADDR_LATE_COUNT) begin
            late_counter <= reg_wdata[`COUNT_W-1:0];
        end else begin
            late_counter <= next_late_counter;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sample_counter <= 20'h00000;
        end else if (wr_open && reg_addr == `ADDR_SAMPLE_COUNT) begin
            sample_counter <= reg_wdata[`COUNT_W-1:0];
        end else begin
            sample_counter <= next_sample_counter;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            latency_sum <= 32'h00000000;
        end else if (wr_open && reg_addr == `ADDR_LATENCY_SUM) begin
            latency_sum <= reg_wdata;
        end else begin
            latency_sum <= next_latency_sum;
        end
    end

    // ----------------------------------------------------------------
    // Suspension
    // ----------------------------------------------------------------
    logic                   at_limit;

    always_comb begin
        // Sum may step past the mark, so compare rather than match
        at_limit = sample_counter == `COUNT_MAX || late_counter == `COUNT_MAX
                   || latency_sum >= `SUM_MAX;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            check_suspended <= 1'b0;
        end else if (enable_rise || (read_check_enable && rd_lat)) begin
            check_suspended <= 1'b0;
        end else if (read_check_enable && (rd_ctl || at_limit)) begin
            check_suspended <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    logic [31:0]            ctl_word;

    always_comb begin
        ctl_word = {read_check_enable, counter_test_hold, timer_test_preload, last_beat_select,
                    late_limit, 4'h0, latest_read_cycles};
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `ADDR_MAP_3_0:       reg_rdata <= map_word(id_map, id_enable, 0);
                `ADDR_MAP_7_4:       reg_rdata <= map_word(id_map, id_enable, 4);
                `ADDR_MAP_11_8:      reg_rdata <= map_word(id_map, id_enable, 8);
                `ADDR_MAP_15_12:     reg_rdata <= map_word(id_map, id_enable, 12);
                `ADDR_ID_ENABLE,
                `ADDR_ID_ENABLE_OLD: reg_rdata <= {16'h0000, id_enable};
                `ADDR_CHECK_CTL,
                `ADDR_CHECK_CTL_OLD: reg_rdata <= ctl_word;
                `ADDR_LATE_COUNT:    reg_rdata <= {12'h000, late_counter};
                `ADDR_SAMPLE_COUNT:  reg_rdata <= {12'h000, sample_counter};
                `ADDR_LATENCY_SUM:   reg_rdata <= latency_sum;
                default:             reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule : read_latency_monitor

// ---- bench/read_latency_monitor_chk.sv ----
// Port-level assertions for the read latency monitor
module read_latency_monitor_chk
    import read_latency_monitor_pkg::*;
(
    input wire logic         clk_sys,
    input wire logic         rst_n,
    input wire logic [11:0]  reg_addr,
    input wire logic [31:0]  reg_wdata,
    input wire logic         reg_wr,
    input wire logic         reg_rd,
    input wire logic [31:0]  reg_rdata,
    input wire logic [127:0] id_map_strap,
    input wire logic [15:0]  id_enable_strap,
    input wire logic [3:0]   job_ring_axi_id,
    input wire logic [3:0]   burst_buffer_axi_id,
    input wire logic [3:0]   descriptor_controller_zero_axi_id,
    input wire logic [2:0]   requester_id_valid,
    input wire logic         check_suspended
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------
    // Shadow of the enable bit, seen from bus writes
    // ------------------------------------------------
    logic en_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= 1'b0;
        end else if (reg_wr && (reg_addr == 12'h530 || reg_addr == 12'h260)) begin
            en_q <= reg_wdata[31];
        end
    end

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    a_enable_read: assert property ($past(reg_rd) && ($past(reg_addr) == 12'h524 || $past(reg_addr) == 12'h250)
        |-> reg_rdata == {16'h0000, id_enable_strap}) else $error("enable readback wrong");
    a_map_top_lane: assert property ($past(reg_rd) && $past(reg_addr) == 12'h518
        |-> reg_rdata[31:24] == (id_enable_strap[15] ? id_map_strap[127:120] : 8'h00)) else $error("ID15 lane wrong");
    a_map_low_lane: assert property ($past(reg_rd) && $past(reg_addr) == 12'h518
        |-> reg_rdata[7:0] == (id_enable_strap[12] ? id_map_strap[103:96] : 8'h00)) else $error("ID12 lane wrong");
    a_alloc_enabled: assert property (requester_id_valid[0] |-> id_enable_strap[job_ring_axi_id])
        else $error("job ring ID not enabled");
    a_alloc_lowest: assert property (requester_id_valid[0]
        |-> (id_enable_strap & ((16'h0001 << job_ring_axi_id) - 16'h0001)) == 16'h0000) else $error("ID not lowest");
    a_alloc_order: assert property (requester_id_valid == 3'b111 |-> job_ring_axi_id < burst_buffer_axi_id
        && burst_buffer_axi_id < descriptor_controller_zero_axi_id) else $error("IDs not distinct ascending");
    a_suspend_read: assert property (reg_rd && en_q && (reg_addr == 12'h530 || reg_addr == 12'h260)
        |=> check_suspended) else $error("control read did not suspend");
    a_resume_clear: assert property (reg_rd && en_q && reg_addr == 12'h53C |=> !check_suspended)
        else $error("latency read did not resume");
endmodule : read_latency_monitor_chk

bind read_latency_monitor read_latency_monitor_chk chk (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .id_map_strap, .id_enable_strap, .job_ring_axi_id, .burst_buffer_axi_id,
    .descriptor_controller_zero_axi_id, .requester_id_valid, .check_suspended);

// ---- bench/axi_read_slave_model.sv ----
// Behavioural AXI read responder, one burst at a time
module axi_read_slave_model (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       ar_valid,
    input  wire logic [3:0] ar_id,
    input  wire logic       r_ready,
    input  var  int         delay,
    input  var  int         beats,
    output logic            ar_ready,
    output logic            r_valid,
    output logic      [3:0] r_id,
    output logic            r_last,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ps;
    int         cnt;
    int         left;
    logic [3:0] id_q;

    assign ar_ready = !busy;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            r_valid <= 1'b0;
            r_id <= 4'h0;
            r_last <= 1'b0;
            cnt <= 0;
            left <= 0;
            id_q <= 4'h0;
        end else if (!busy) begin
            // Idle ID lines keep changing so a stale ID never looks valid
            r_id <= ~r_id;
            if (ar_valid) begin
                busy <= 1'b1;
                id_q <= ar_id;
                cnt <= delay - 2;
                left <= beats;
            end
        end else if (!r_valid) begin
            r_id <= ~r_id;
            if (cnt == 0) begin
                r_valid <= 1'b1;
                r_id <= id_q;
                r_last <= (left == 1);
            end else begin
                cnt <= cnt - 1;
            end
        end else if (r_ready) begin
            if (left == 1) begin
                r_valid <= 1'b0;
                r_last <= 1'b0;
                r_id <= ~id_q;
                busy <= 1'b0;
            end else begin
                left <= left - 1;
                r_last <= (left == 2);
            end
        end
    end
endmodule : axi_read_slave_model

// ---- bench/testbench.sv ----
// Self-checking bench for the read latency monitor
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import read_latency_monitor_pkg::*;
    logic         clk_sys = 1'b0;
    logic         rst_n = 1'b0;
    logic [11:0]  reg_addr = 12'h000;
    logic [31:0]  reg_wdata = 32'h0;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic [31:0]  reg_rdata;
    logic [127:0] id_map_strap = {8{8'h08, 8'h01}};
    logic [15:0]  id_enable_strap = 16'h90D2;
    logic         ar_valid = 1'b0;
    logic         ar_ready;
    logic [3:0]   ar_id = 4'h0;
    logic         r_valid;
    logic         r_ready = 1'b1;
    logic [3:0]   r_id;
    logic         r_last;
    logic [3:0]   job_ring_axi_id;
    logic [3:0]   burst_buffer_axi_id;
    logic [3:0]   descriptor_controller_zero_axi_id;
    logic [2:0]   requester_id_valid;
    logic         check_suspended;
    logic         busy;
    int           delay = 2;
    int           beats = 1;
    int           bad_count = 0;
    int           n_tests = 0;

    always #2.5 clk_sys = ~clk_sys;

    read_latency_monitor DUT (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .id_map_strap, .id_enable_strap, .ar_valid, .ar_ready, .ar_id, .r_valid, .r_ready, .r_id, .r_last,
        .job_ring_axi_id, .burst_buffer_axi_id, .descriptor_controller_zero_axi_id, .requester_id_valid,
        .check_suspended);
    axi_read_slave_model partner (.clk_sys, .rst_n, .ar_valid, .ar_id, .r_ready, .delay, .beats, .ar_ready,
        .r_valid, .r_id, .r_last, .busy);

    // ------------------------------------------------
    // Shared tasks
    // ------------------------------------------------
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask : rdc

    // Latency seen by the monitor is d cycles to the first beat
    task automatic axi_read(input logic [3:0] id, input int d, input int b);
        int i;
        delay = d;
        beats = b;
        i = 0;
        @(posedge clk_sys);
        ar_valid <= 1'b1;
        ar_id <= id;
        do begin
            @(posedge clk_sys);
            i++;
        end while (ar_ready !== 1'b1 && i < 100);
        if (ar_ready !== 1'b1) begin
            bad_count++;
            $display("ERROR %0t: address handshake timed out", $time);
            wrap_up();
        end
        ar_valid <= 1'b0;
        ar_id <= ~id;
        #1;
        while (busy !== 1'b0 && i < 5000) begin
            @(posedge clk_sys);
            i++;
        end
        if (i >= 5000) begin
            bad_count++;
            $display("ERROR %0t: read burst timed out", $time);
            wrap_up();
        end
        repeat (2) @(posedge clk_sys);
    endtask : axi_read

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic straps_test;
        rdc(12'h524, 32'h000090D2);
        rdc(12'h250, 32'h000090D2);
        wr(12'h524, 32'hFFFFFFFF);
        wr(12'h518, 32'h00000000);
        rdc(12'h524, 32'h000090D2);
        rdc(12'h518, 32'h08000001);
        rdc(12'h51C, 32'h00000000);
        rdc(12'h510, 32'h08010001);
        rdc(12'h514, 32'h00000800);
        check({17'h0, requester_id_valid, descriptor_controller_zero_axi_id, burst_buffer_axi_id,
            job_ring_axi_id}, 32'h00007641);
    endtask : straps_test

    task automatic measure_test;
        wr(12'h530, 32'h80040000);
        axi_read(4'h3, 4, 2);
        axi_read(4'h5, 3, 1);
        rdc(12'h534, 32'h00000001);
        wr(12'h538, 32'h00000055);
        wr(12'h530, 32'h80FF0000);
        rdc(12'h538, 32'h00000002);
        rdc(12'h53C, 32'h00000007);
        rdc(12'h538, 32'h00000000);
        rdc(12'h530, 32'h80040003);
        check({31'h0, check_suspended}, 32'h1);
        axi_read(4'h3, 4, 1);
        rdc(12'h538, 32'h00000000);
        rdc(12'h53C, 32'h00000000);
        check({31'h0, check_suspended}, 32'h0);
    endtask : measure_test

    task automatic last_beat_test;
        wr(12'h530, 32'h00000000);
        wr(12'h530, 32'h90000000);
        axi_read(4'h1, 2, 3);
        rdc(12'h534, 32'h00000001);
        rdc(12'h53C, 32'h00000004);
    endtask : last_beat_test

    task automatic timer_test;
        wr(12'h530, 32'h00000000);
        wr(12'h260, 32'hA0000000);
        axi_read(4'h2, 20, 1);
        rdc(12'h53C, 32'h00000FFF);
        axi_read(4'h2, 5, 1);
        rdc(12'h530, 32'hA0000FF5);
    endtask : timer_test

    // Preloaded counters shorten the run to saturation
    task automatic counter_test;
        wr(12'h530, 32'h00000000);
        wr(12'h538, 32'h000FFFFE);
        wr(12'h534, 32'h00000007);
        wr(12'h53C, 32'h00000064);
        wr(12'h530, 32'hC0000000);
        rdc(12'h534, 32'h00000007);
        axi_read(4'h4, 3, 1);
        check({31'h0, check_suspended}, 32'h1);
        rdc(12'h538, 32'h000FFFFF);
        rdc(12'h534, 32'h00000008);
        rdc(12'h53C, 32'h00000067);
    endtask : counter_test

    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        straps_test();
        measure_test();
        last_beat_test();
        timer_test();
        counter_test();
        wrap_up();
    end
endmodule : testbench
